// [core/dcsp_chan.sv]
// one serial channel: 1x bit clock transmitter and receiver, small rx fifo
// assumes rise_i and fall_i are one-cycle pulses of the selected bit clock
`timescale 1ns/1ns
module dcsp_chan import dcsp_pkg::*; #(
  parameter int CW = DCSP_CHAR_BITS,
  parameter int DEPTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic rx_i,
  input wire logic cts_n_i,
  input wire logic tx_en_i,
  input wire logic rx_en_i,
  input wire logic loop_i,
  input wire logic cts_en_i,
  input wire logic tx_wr_i,
  input wire logic [CW-1:0] tx_dat_i,
  input wire logic rx_rd_i,
  output logic tx_o,
  output logic [CW-1:0] rx_dat_o,
  output dcsp_chst_t st_o
);
  localparam int BW = $clog2(CW);
  localparam int PW = $clog2(DEPTH);
  localparam int NW = $clog2(DEPTH + 1);

  logic [CW-1:0] thr_r, tsr_r, rsr_r;
  logic thr_v_r, tline_r, ferr_r;
  dcsp_ser_t ts_r, rs_r;
  logic [BW-1:0] tbit_r, rbit_r;
  logic [CW-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, rp_r;
  logic [NW-1:0] cnt_r;

  // clear-to-send gates the start of a character
  wire cts_ok = !cts_en_i || !cts_n_i;
  wire rx_bit = loop_i ? tline_r : rx_i;
  wire fifo_full = cnt_r == NW'(DEPTH);
  wire stop_ok = rise_i && rx_en_i && rs_r == DCSP_S_STOP && rx_bit;
  wire push = stop_ok && !fifo_full;
  wire pop = rx_rd_i && cnt_r != '0;
  wire last_t = tbit_r == BW'(CW - 1);
  wire last_r = rbit_r == BW'(CW - 1);

  // ****************************************
  // transmitter
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thr_r <= '0;
      tsr_r <= '0;
      thr_v_r <= 1'b0;
      tline_r <= 1'b1;
      ts_r <= DCSP_S_IDLE;
      tbit_r <= '0;
      tx_o <= 1'b1;
    end
    else
    begin
      if (!tx_en_i)
      begin
        ts_r <= DCSP_S_IDLE;
        tline_r <= 1'b1;
      end
      else if (fall_i)
      begin
        // shift on falling edge, lsb first
        case (ts_r)
          DCSP_S_IDLE:
          begin
            if (thr_v_r && cts_ok)
            begin
              tsr_r <= thr_r;
              thr_v_r <= 1'b0;
              tline_r <= 1'b0;
              tbit_r <= '0;
              ts_r <= DCSP_S_DATA;
            end
          end
          DCSP_S_DATA:
          begin
            tline_r <= tsr_r[0];
            tsr_r <= tsr_r >> 1;
            tbit_r <= tbit_r + 1'b1;
            if (last_t)
              ts_r <= DCSP_S_STOP;
          end
          DCSP_S_STOP:
          begin
            tline_r <= 1'b1;
            ts_r <= DCSP_S_IDLE;
          end
          default: ts_r <= DCSP_S_IDLE;
        endcase
      end
      // a write in the same cycle as a load still lands in the holding register
      if (tx_wr_i)
      begin
        thr_r <= tx_dat_i;
        thr_v_r <= 1'b1;
      end
      // mark when disabled, idle or looped back
      tx_o <= (!tx_en_i || loop_i) ? 1'b1 : tline_r;
    end
  end

  // ****************************************
  // receiver and fifo
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rs_r <= DCSP_S_IDLE;
      rsr_r <= '0;
      rbit_r <= '0;
      ferr_r <= 1'b0;
    end
    else
    begin
      ferr_r <= rise_i && rx_en_i && rs_r == DCSP_S_STOP && !rx_bit;
      if (!rx_en_i)
        rs_r <= DCSP_S_IDLE;
      else if (rise_i)
      begin
        // sample on rising edge, lsb first
        case (rs_r)
          DCSP_S_IDLE:
          begin
            if (!rx_bit)
            begin
              rbit_r <= '0;
              rs_r <= DCSP_S_DATA;
            end
          end
          DCSP_S_DATA:
          begin
            rsr_r <= {rx_bit, rsr_r[CW-1:1]};
            rbit_r <= rbit_r + 1'b1;
            if (last_r)
              rs_r <= DCSP_S_STOP;
          end
          default: rs_r <= DCSP_S_IDLE;
        endcase
      end
    end
  end

  // overrun drops the new character; held characters are kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= rsr_r;
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop)
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + NW'(push) - NW'(pop);
    end
  end

  assign rx_dat_o = (cnt_r != '0) ? mem_r[rp_r] : '0;
  assign st_o.rx_rdy = cnt_r != '0;
  assign st_o.ffull = fifo_full;
  assign st_o.tx_rdy = !thr_v_r;
  assign st_o.tx_empty = !thr_v_r && ts_r == DCSP_S_IDLE;
  assign st_o.ferr_evt = ferr_r;
endmodule

// [core/dcsp_pkg.sv]
// constants, types and register map of the dual channel serial pin logic
// assumes one 10 MHz clock and a classic wishbone slave port with 32-bit data
package dcsp_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int DCSP_AW = 8;
  localparam logic [7:0] DCSP_CTRL_OFS = 8'h00;
  localparam logic [7:0] DCSP_BAUD_OFS = 8'h04;
  localparam logic [7:0] DCSP_OPORT_OFS = 8'h08;
  localparam logic [7:0] DCSP_TXA_OFS = 8'h0C;
  localparam logic [7:0] DCSP_RXA_OFS = 8'h10;
  localparam logic [7:0] DCSP_STA_OFS = 8'h14;
  localparam logic [7:0] DCSP_TXB_OFS = 8'h18;
  localparam logic [7:0] DCSP_RXB_OFS = 8'h1C;
  localparam logic [7:0] DCSP_STB_OFS = 8'h20;
  localparam logic [7:0] DCSP_ISR_OFS = 8'h24;
  localparam logic [7:0] DCSP_IMR_OFS = 8'h28;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int DCSP_CHAR_BITS = 8;
  localparam int DCSP_BAUD_W = 16;
  localparam logic [15:0] DCSP_BAUD_RST = 16'h0010;
  localparam logic [7:0] DCSP_OPORT_RST = 8'hFF;
  localparam int DCSP_OP_REQUEST_TO_SEND_OUT_A = 0;
  localparam int DCSP_OP_REQUEST_TO_SEND_OUT_B = 1;
  localparam int DCSP_OP_RXRDY = 4;
  localparam int DCSP_OP_TXRDY = 6;
  localparam int DCSP_ST_RXRDY = 0;
  localparam int DCSP_ST_FFULL = 1;
  localparam int DCSP_ST_TXRDY = 2;
  localparam int DCSP_ST_TXEMT = 3;
  localparam int DCSP_ST_FERR = 4;
  localparam int DCSP_ST_W = 5;
  localparam int DCSP_IS_TXRDYA = 0;
  localparam int DCSP_IS_RXA = 1;
  localparam int DCSP_IS_FERRA = 2;
  localparam int DCSP_IS_TXRDYB = 3;
  localparam int DCSP_IS_RXB = 4;
  localparam int DCSP_IS_FERRB = 5;
  localparam int DCSP_ISR_W = 6;
  localparam int DCSP_CTRL_W = 15;
  localparam int DCSP_SYNC_W = 5;

  typedef enum logic [1:0] {
    DCSP_RXPIN_RDY,
    DCSP_RXPIN_FFULL,
    DCSP_RXPIN_DISC
  } dcsp_rxpin_t;

  typedef enum logic [1:0] {
    DCSP_S_IDLE,
    DCSP_S_DATA,
    DCSP_S_STOP
  } dcsp_ser_t;

  // index 0 is channel a, index 1 is channel b
  typedef struct packed {
    dcsp_rxpin_t rxpin_mode;
    logic txrdy_disc;
    logic [1:0] rts_hs;
    logic [1:0] cts_en;
    logic [1:0] sclk_sel;
    logic [1:0] loop;
    logic [1:0] rx_en;
    logic [1:0] tx_en;
  } dcsp_ctrl_t;

  localparam dcsp_ctrl_t DCSP_CTRL_RST = dcsp_ctrl_t'(15'h0000);

  typedef struct packed {
    logic ferr_evt;
    logic tx_empty;
    logic tx_rdy;
    logic ffull;
    logic rx_rdy;
  } dcsp_chst_t;

endpackage

// [core/dcsp_sync.sv]
// two flip-flop synchroniser for a group of asynchronous pins
// assumes each bit is independent; no bus coherency across bits
`timescale 1ns/1ns
module dcsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// [core/dcsp_top.sv]
// dual channel serial pin logic: wishbone registers, bit clocks, pin muxes
// assumes a classic wishbone master on clk_i and asynchronous serial pins
`timescale 1ns/1ns
module dcsp_top import dcsp_pkg::*; #(
  parameter int RX_DEPTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DCSP_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic serial_in_a_i,
  input wire logic serial_in_b_i,
  input wire logic clear_to_send_in_a_n_i,
  input wire logic clear_to_send_in_b_n_i,
  input wire logic serial_ext_clk_i,
  output logic serial_out_a_o,
  output logic serial_out_b_o,
  output logic request_to_send_out_a_n_o,
  output logic request_to_send_out_b_n_o,
  output logic tx_ready_pin_a_n_o,
  output logic rx_ready_pin_a_n_o
);
  localparam int CW = DCSP_CHAR_BITS;

  dcsp_ctrl_t ctrl_r;
  logic [DCSP_BAUD_W-1:0] baud_r, bcnt_r;
  logic [7:0] oport_r;
  logic [DCSP_ISR_W-1:0] isr_r, imr_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic bclk_r, sclk_d_r;
  logic [DCSP_SYNC_W-1:0] pins_s;
  logic [CW-1:0] rxd_a, rxd_b;
  dcsp_chst_t st_a, st_b;
  logic rts_a_r, rts_b_r, txrdy_r, rxrdy_r;

  // ****************************************
  // wishbone decode
  // ****************************************
  // ack is registered: each access sees exactly one wait state
  // !ack_r stops a request held through its ack cycle being taken twice
  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr = req && wb_we_i;
  wire rd = req && !wb_we_i;

  // low address bits ignored: every register is one word
  wire [DCSP_AW-1:0] adr = {wb_adr_i[DCSP_AW-1:2], 2'b00};
  wire hit_ctrl = adr == DCSP_CTRL_OFS;
  wire hit_baud = adr == DCSP_BAUD_OFS;
  wire hit_oport = adr == DCSP_OPORT_OFS;
  wire hit_txa = adr == DCSP_TXA_OFS;
  wire hit_rxa = adr == DCSP_RXA_OFS;
  wire hit_sta = adr == DCSP_STA_OFS;
  wire hit_txb = adr == DCSP_TXB_OFS;
  wire hit_rxb = adr == DCSP_RXB_OFS;
  wire hit_stb = adr == DCSP_STB_OFS;
  wire hit_isr = adr == DCSP_ISR_OFS;
  wire hit_imr = adr == DCSP_IMR_OFS;

  // ctrl and baud honour every lane; the others need lane 0
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] ctrl_w = {{(32 - DCSP_CTRL_W){1'b0}}, ctrl_r};
  wire [31:0] ctrl_new = (ctrl_w & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] baud_w = {{(32 - DCSP_BAUD_W){1'b0}}, baud_r};
  wire [31:0] baud_new = (baud_w & ~wmask) | (wb_dat_i & wmask);
  wire tx_wr_a = wr && hit_txa && wb_sel_i[0];
  wire tx_wr_b = wr && hit_txb && wb_sel_i[0];
  wire rx_rd_a = rd && hit_rxa;
  wire rx_rd_b = rd && hit_rxb;

  // status words are the channel structs, bit for bit
  wire [DCSP_ST_W-1:0] stat_a = st_a;
  wire [DCSP_ST_W-1:0] stat_b = st_b;

  // unmapped offsets read as zero and drop writes
  wire [31:0] rmux =
    hit_ctrl ? ctrl_w :
    hit_baud ? baud_w :
    hit_oport ? {24'h000000, oport_r} :
    hit_rxa ? {{(32 - CW){1'b0}}, rxd_a} :
    hit_sta ? {{(32 - DCSP_ST_W){1'b0}}, stat_a} :
    hit_rxb ? {{(32 - CW){1'b0}}, rxd_b} :
    hit_stb ? {{(32 - DCSP_ST_W){1'b0}}, stat_b} :
    hit_isr ? {{(32 - DCSP_ISR_W){1'b0}}, isr_r} :
    hit_imr ? {{(32 - DCSP_ISR_W){1'b0}}, imr_r} :
    32'h00000000;

  // ****************************************
  // register file
  // ****************************************
  // read data is taken at the taking edge so it stands with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= DCSP_CTRL_RST;
      baud_r <= DCSP_BAUD_RST;
      oport_r <= DCSP_OPORT_RST;
      imr_r <= '0;
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= req;
      if (rd)
        rdat_r <= rmux;
      if (wr && hit_ctrl)
        ctrl_r <= dcsp_ctrl_t'(ctrl_new[DCSP_CTRL_W-1:0]);
      if (wr && hit_baud)
        baud_r <= baud_new[DCSP_BAUD_W-1:0];
      if (wr && hit_oport && wb_sel_i[0])
        oport_r <= wb_dat_i[7:0];
      if (wr && hit_imr && wb_sel_i[0])
        imr_r <= wb_dat_i[DCSP_ISR_W-1:0];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ****************************************
  // interrupt status
  // ****************************************
  // rx bit follows the pin mode: character held or fifo full
  wire rxa_cond = (ctrl_r.rxpin_mode == DCSP_RXPIN_FFULL) ? st_a.ffull : st_a.rx_rdy;
  wire rxb_cond = (ctrl_r.rxpin_mode == DCSP_RXPIN_FFULL) ? st_b.ffull : st_b.rx_rdy;
  wire [DCSP_ISR_W-1:0] isr_set = {st_b.ferr_evt, rxb_cond, st_b.tx_rdy,
                                   st_a.ferr_evt, rxa_cond, st_a.tx_rdy};
  wire [DCSP_ISR_W-1:0] isr_clr = (rd && hit_isr) ? isr_r : '0;

  // level conditions re-set at once after a read while they still hold
  // a read clears only what it returned; a same-cycle set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      isr_r <= '0;
    else
      isr_r <= (isr_r & ~isr_clr) | isr_set;
  end

  // level output: high until every unmasked bit is read away
  assign irq_o = |(isr_r & imr_r);

  // ****************************************
  // pin synchronisers and bit clocks
  // ****************************************
  // reset value 1: lines at mark, clear-to-send deasserted
  // async pins synchronised
  dcsp_sync #(
    .W(DCSP_SYNC_W),
    .RST_VAL(5'h1F)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({serial_ext_clk_i, clear_to_send_in_b_n_i, clear_to_send_in_a_n_i,
          serial_in_b_i, serial_in_a_i}),
    .q_o(pins_s)
  );

  // baud generator: half period of baud_r + 1 cycles
  // a value below the running count waits for the counter to wrap
  wire bwrap = bcnt_r == baud_r;
  wire brise = bwrap && !bclk_r;
  wire bfall = bwrap && bclk_r;
  // the external clock must stay below a quarter of clk_i
  wire srise = pins_s[4] && !sclk_d_r;
  wire sfall = !pins_s[4] && sclk_d_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bcnt_r <= '0;
      bclk_r <= 1'b0;
      sclk_d_r <= 1'b1;
    end
    else
    begin
      bcnt_r <= bwrap ? '0 : bcnt_r + 1'b1;
      if (bwrap)
        bclk_r <= !bclk_r;
      sclk_d_r <= pins_s[4];
    end
  end

  // the external clock costs two cycles of synchroniser lag
  // external clock bypasses the baud generator
  wire rise_a = ctrl_r.sclk_sel[0] ? srise : brise;
  wire fall_a = ctrl_r.sclk_sel[0] ? sfall : bfall;
  wire rise_b = ctrl_r.sclk_sel[1] ? srise : brise;
  wire fall_b = ctrl_r.sclk_sel[1] ? sfall : bfall;

  // ****************************************
  // channels
  // ****************************************
  // both share the baud generator; only the clock select differs
  dcsp_chan #(
    .CW(CW),
    .DEPTH(RX_DEPTH)
  ) u_chan_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rise_i(rise_a),
    .fall_i(fall_a),
    .rx_i(pins_s[0]),
    .cts_n_i(pins_s[2]),
    .tx_en_i(ctrl_r.tx_en[0]),
    .rx_en_i(ctrl_r.rx_en[0]),
    .loop_i(ctrl_r.loop[0]),
    .cts_en_i(ctrl_r.cts_en[0]),
    .tx_wr_i(tx_wr_a),
    .tx_dat_i(wb_dat_i[CW-1:0]),
    .rx_rd_i(rx_rd_a),
    .tx_o(serial_out_a_o),
    .rx_dat_o(rxd_a),
    .st_o(st_a)
  );

  dcsp_chan #(
    .CW(CW),
    .DEPTH(RX_DEPTH)
  ) u_chan_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rise_i(rise_b),
    .fall_i(fall_b),
    .rx_i(pins_s[1]),
    .cts_n_i(pins_s[3]),
    .tx_en_i(ctrl_r.tx_en[1]),
    .rx_en_i(ctrl_r.rx_en[1]),
    .loop_i(ctrl_r.loop[1]),
    .cts_en_i(ctrl_r.cts_en[1]),
    .tx_wr_i(tx_wr_b),
    .tx_dat_i(wb_dat_i[CW-1:0]),
    .rx_rd_i(rx_rd_b),
    .tx_o(serial_out_b_o),
    .rx_dat_o(rxd_b),
    .st_o(st_b)
  );

  // ****************************************
  // multiplexed output pins
  // ****************************************
  // every pin is registered so decode glitches stay inside
  // handshake level is tx_empty: low from write to stop bit
  // handshake asserts low while a character is pending or on the line
  // discrete mode follows output port bits
  wire rts_a_nxt = ctrl_r.rts_hs[0] ? st_a.tx_empty : oport_r[DCSP_OP_REQUEST_TO_SEND_OUT_A];
  wire rts_b_nxt = ctrl_r.rts_hs[1] ? st_b.tx_empty : oport_r[DCSP_OP_REQUEST_TO_SEND_OUT_B];
  wire txrdy_nxt = ctrl_r.txrdy_disc ? oport_r[DCSP_OP_TXRDY] : !stat_a[DCSP_ST_TXRDY];
  logic rxrdy_nxt;

  // the pin follows the sticky isr bit, so a status read frees it
  // rx pin mode select
  always_comb
  begin
    rxrdy_nxt = oport_r[DCSP_OP_RXRDY];
    case (ctrl_r.rxpin_mode)
      // rx ready from isr bit 1
      DCSP_RXPIN_RDY: rxrdy_nxt = !isr_r[DCSP_IS_RXA];
      // fifo full from isr bit 1
      DCSP_RXPIN_FFULL: rxrdy_nxt = !isr_r[DCSP_IS_RXA];
      DCSP_RXPIN_DISC: rxrdy_nxt = oport_r[DCSP_OP_RXRDY];
      default: rxrdy_nxt = oport_r[DCSP_OP_RXRDY];
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rts_a_r <= 1'b1;
      rts_b_r <= 1'b1;
      txrdy_r <= 1'b1;
      rxrdy_r <= 1'b1;
    end
    else
    begin
      rts_a_r <= rts_a_nxt;
      rts_b_r <= rts_b_nxt;
      txrdy_r <= txrdy_nxt;
      rxrdy_r <= rxrdy_nxt;
    end
  end

  // reset drives every pin high, inactive for the low-true ones
  // pins lag their cause by one cycle
  assign request_to_send_out_a_n_o = rts_a_r;
  assign request_to_send_out_b_n_o = rts_b_r;
  assign tx_ready_pin_a_n_o = txrdy_r;
  assign rx_ready_pin_a_n_o = rxrdy_r;
endmodule

// [dv/dcsp_checker.sv]
// pin and bus checks for the dual channel serial pin logic
// assumes a classic wishbone master that holds each request until ack
`timescale 1ns/1ns
module dcsp_checker import dcsp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DCSP_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic serial_ext_clk_i,
  input wire logic serial_out_a_o,
  input wire logic request_to_send_out_a_n_o,
  input wire logic request_to_send_out_b_n_o,
  input wire logic tx_ready_pin_a_n_o,
  input wire logic rx_ready_pin_a_n_o
);
  // shadow updates on the taking edge; only writes with lane 0 enabled are followed
  dcsp_ctrl_t ctl_r;
  logic [7:0] op_r;
  logic [7:0] imr_r;
  logic wr_w;
  logic [5:0] ofs_w;
  assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign ofs_w = wb_adr_i[7:2];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_r <= DCSP_CTRL_RST;
      op_r <= DCSP_OPORT_RST;
      imr_r <= 8'h00;
    end
    else if (wr_w)
    begin
      if (ofs_w == DCSP_CTRL_OFS[7:2])
        ctl_r <= dcsp_ctrl_t'(wb_dat_i[14:0]);
      if (ofs_w == DCSP_OPORT_OFS[7:2])
        op_r <= wb_dat_i[7:0];
      if (ofs_w == DCSP_IMR_OFS[7:2])
        imr_r <= wb_dat_i[7:0];
    end
  end

  default clocking dcsp_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  AST_IRQ_MASK: assert property (imr_r == 8'h00 |-> !irq_o)
    else $error("interrupt while all sources masked");
  AST_TX_MARK: assert property (
    (ctl_r.loop[0] || !ctl_r.tx_en[0]) [*3] |-> serial_out_a_o)
    else $error("tx line a left mark while disabled or looped");
  AST_TX_FALL: assert property (
    ctl_r.sclk_sel[0] && ctl_r.tx_en[0] && $changed(serial_out_a_o) |-> !serial_ext_clk_i)
    else $error("tx line a moved outside low phase of bit clock");
  AST_RTS_HS: assert property (
    ctl_r.rts_hs[0] && !serial_out_a_o && !$past(serial_out_a_o)
    |-> !request_to_send_out_a_n_o)
    else $error("rts a not asserted while sending");
  AST_RTS_A: assert property (
    !ctl_r.rts_hs[0] |=> request_to_send_out_a_n_o == $past(op_r[DCSP_OP_REQUEST_TO_SEND_OUT_A]))
    else $error("rts a not following port bit");
  AST_RTS_B: assert property (
    !ctl_r.rts_hs[1] |=> request_to_send_out_b_n_o == $past(op_r[DCSP_OP_REQUEST_TO_SEND_OUT_B]))
    else $error("rts b not following port bit");
  AST_TXRDY_DISC: assert property (
    ctl_r.txrdy_disc |=> tx_ready_pin_a_n_o == $past(op_r[DCSP_OP_TXRDY]))
    else $error("tx ready pin not following port bit");
  AST_RX_DISC: assert property (
    ctl_r.rxpin_mode[1] |=> rx_ready_pin_a_n_o == $past(op_r[DCSP_OP_RXRDY]))
    else $error("rx pin not following port bit");
  AST_RX_STAT: assert property (
    !ctl_r.rxpin_mode[1] && imr_r == 8'h02 |=> rx_ready_pin_a_n_o == !$past(irq_o))
    else $error("rx pin not the inverse of rx status");

  cover property (wb_ack_o && wb_we_i);
  cover property ($fell(rx_ready_pin_a_n_o));
  cover property ($rose(irq_o));
endmodule

bind dcsp_top dcsp_checker dcsp_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o), .serial_ext_clk_i(serial_ext_clk_i),
  .serial_out_a_o(serial_out_a_o),
  .request_to_send_out_a_n_o(request_to_send_out_a_n_o),
  .request_to_send_out_b_n_o(request_to_send_out_b_n_o),
  .tx_ready_pin_a_n_o(tx_ready_pin_a_n_o), .rx_ready_pin_a_n_o(rx_ready_pin_a_n_o)
);

// [dv/dcsp_peer.sv]
// remote serial partner: free running bit clock, 8N1 sender and receiver
// assumes the device uses this clock for both channels; index 0 is channel a
`timescale 1ns/1ns
module dcsp_peer (
  input wire logic clk_i,
  input wire logic [1:0] txd_i,
  output logic sclk_o,
  output logic [1:0] rxd_o
);
  // bit period of 16 system cycles keeps the clock well below clk/4
  logic [3:0] div_r = 4'h0;
  logic [3:0] cnt_r [2] = '{4'h0, 4'h0};
  logic [8:0] sh_r [2];
  int got_q [$];
  initial rxd_o = 2'b11;
  assign sclk_o = div_r[3];
  always @(posedge clk_i)
    div_r <= div_r + 4'h1;
  always @(posedge clk_i)
    if (div_r == 4'h7)
      for (int c = 0; c < 2; c++)
        if (cnt_r[c] == 4'h0)
        begin
          if (txd_i[c] === 1'b0)
            cnt_r[c] = 4'h1;
        end
        else
        begin
          sh_r[c] = {txd_i[c], sh_r[c][8:1]};
          // a bad stop bit is reported with 512 added
          if (cnt_r[c] == 4'h9)
          begin
            got_q.push_back(c * 256 + (sh_r[c][8] ? 0 : 512) + sh_r[c][7:0]);
            cnt_r[c] = 4'h0;
          end
          else
            cnt_r[c] = cnt_r[c] + 4'h1;
        end
  task automatic send(input int c, input logic [7:0] d, input logic stop);
    logic [10:0] f;
    f = {1'b1, stop, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk_i iff div_r == 4'hF);
      rxd_o[c] <= f[i];
    end
  endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench for the dual channel serial pin logic
// assumes the peer model owns the serial lines and the external bit clock
`timescale 1ns/1ns
module tb_top import dcsp_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_q;
  logic wb_ack, irq, sclk, rts_a_n, rts_b_n, txp_n, rxp_n;
  wire [1:0] sout, sin;
  logic cts_a_n = 1'b0;
  logic cts_b_n = 1'b0;
  logic [7:0] seed = 8'h02;
  logic [31:0] q;
  int bad_count = 0;
  int checked = 0;
  int tests = 0;
  int exp_q [$];

  initial forever #50 clk_i = ~clk_i;

  dcsp_top dcsp_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
    .wb_ack_o(wb_ack), .irq_o(irq), .serial_in_a_i(sin[0]), .serial_in_b_i(sin[1]),
    .clear_to_send_in_a_n_i(cts_a_n), .clear_to_send_in_b_n_i(cts_b_n),
    .serial_ext_clk_i(sclk), .serial_out_a_o(sout[0]), .serial_out_b_o(sout[1]),
    .request_to_send_out_a_n_o(rts_a_n), .request_to_send_out_b_n_o(rts_b_n),
    .tx_ready_pin_a_n_o(txp_n), .rx_ready_pin_a_n_o(rxp_n));
  dcsp_peer dcsp_peer_i (.clk_i(clk_i), .txd_i(sout), .sclk_o(sclk), .rxd_o(sin));

  function automatic logic [7:0] lfsr();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: pin %b want %b", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // the answer is taken only at the edge that samples ack high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50)
      chk_val(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk_val(q, e);
  endtask

  task automatic wait_q();
    int k;
    k = 0;
    while (dcsp_peer_i.got_q.size() == 0 && k < 2000)
    begin
      ticks(1);
      k++;
    end
  endtask

  task automatic done_test();
    tests++;
    $display("test %0d done at %0t", tests, $time);
  endtask

  initial
  begin
    ticks(30000);
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    logic [7:0] v;
    int c;
    ticks(16);
    rst_i <= 1'b0;
    ticks(2);
    rd(DCSP_CTRL_OFS, 32'h0);
    rd(DCSP_BAUD_OFS, 32'h10);
    rd(DCSP_OPORT_OFS, 32'hFF);
    rd(8'h40, 32'h0);
    chk_pin(rts_a_n, 1'b1);
    done_test();
    wb(1'b1, DCSP_CTRL_OFS, 32'h5000);
    repeat (4)
    begin
      v = lfsr();
      wb(1'b1, DCSP_OPORT_OFS, {24'h0, v});
      ticks(2);
      chk_pin(rts_a_n, v[DCSP_OP_REQUEST_TO_SEND_OUT_A]);
      chk_pin(rts_b_n, v[DCSP_OP_REQUEST_TO_SEND_OUT_B]);
      chk_pin(txp_n, v[DCSP_OP_TXRDY]);
      chk_pin(rxp_n, v[DCSP_OP_RXRDY]);
    end
    done_test();
    wb(1'b1, DCSP_CTRL_OFS, 32'h0CCF);
    ticks(3);
    rd(DCSP_STA_OFS, 32'h0C);
    chk_pin(txp_n, 1'b0);
    chk_pin(rts_a_n, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      c = i % 2;
      v = lfsr();
      wb(1'b1, c ? DCSP_TXB_OFS : DCSP_TXA_OFS, {24'h0, v});
      ticks(2);
      chk_pin(c ? rts_b_n : rts_a_n, 1'b0);
      wait_q();
      chk_val(dcsp_peer_i.got_q.pop_front(), c * 256 + v);
    end
    done_test();
    wb(1'b1, DCSP_IMR_OFS, 32'h02);
    for (int i = 0; i < 2; i++)
    begin
      v = lfsr();
      dcsp_peer_i.send(i, v, 1'b1);
      ticks(6);
      chk_pin(irq, i == 0);
      chk_pin(rxp_n, i != 0);
      rd(i ? DCSP_RXB_OFS : DCSP_RXA_OFS, v);
      rd(DCSP_ISR_OFS, i ? 32'h19 : 32'h0B);
    end
    v = lfsr();
    dcsp_peer_i.send(1, v, 1'b0);
    ticks(6);
    rd(DCSP_ISR_OFS, 32'h29);
    rd(DCSP_RXB_OFS, 32'h0);
    done_test();
    wb(1'b1, DCSP_CTRL_OFS, 32'h2CCF);
    for (int i = 0; i < 4; i++)
    begin
      v = lfsr();
      dcsp_peer_i.send(0, v, 1'b1);
      if (i < 3)
        exp_q.push_back(v);
      ticks(6);
      chk_pin(rxp_n, i < 2);
    end
    for (int i = 0; i < 4; i++)
      rd(DCSP_RXA_OFS, (i < 3) ? exp_q.pop_front() : 0);
    rd(DCSP_ISR_OFS, 32'h0B);
    ticks(2);
    chk_pin(rxp_n, 1'b1);
    done_test();
    wb(1'b1, DCSP_CTRL_OFS, 32'h0CDF);
    v = lfsr();
    wb(1'b1, DCSP_TXA_OFS, {24'h0, v});
    ticks(300);
    chk_val(dcsp_peer_i.got_q.size(), 32'h0);
    rd(DCSP_RXA_OFS, v);
    done_test();
    wb(1'b1, DCSP_CTRL_OFS, 32'h0C1F);
    v = lfsr();
    wb(1'b1, DCSP_TXA_OFS, {24'h0, v});
    ticks(400);
    rd(DCSP_RXA_OFS, v);
    done_test();
    wb(1'b1, DCSP_CTRL_OFS, 32'h0DCF);
    cts_a_n <= 1'b1;
    v = lfsr();
    wb(1'b1, DCSP_TXA_OFS, {24'h0, v});
    ticks(300);
    chk_val(dcsp_peer_i.got_q.size(), 32'h0);
    cts_a_n <= 1'b0;
    wait_q();
    chk_val(dcsp_peer_i.got_q.pop_front(), v);
    done_test();
    print_verdict();
  end
endmodule
